// file: counter_defines.vh
// Constants for the signed counting core: codes, field widths and reset defaults
`ifndef COUNTER_DEFINES_VH
`define COUNTER_DEFINES_VH

// Reaction to the reference pulse
`define REF_NONE 2'h0
`define REF_SYNC 2'h1
`define REF_CAPTURE 2'h2

// Auxiliary input functions
`define AUX_GATE_LEVEL 3'h0
`define AUX_GATE_OPEN 3'h1
`define AUX_GATE_CLOSE 3'h2
`define AUX_SYNC 3'h3
`define AUX_REF_ENABLE 3'h4
`define AUX_CAPTURE 3'h5
`define AUX_NONE 3'h6

// Edge selection for edge-sensitive functions
`define EDGE_RISE 2'h0
`define EDGE_FALL 2'h1
`define EDGE_BOTH 2'h2

// Reset defaults
`define DEF_HI_LIMIT 32'h7fffffff
`define DEF_LO_LIMIT 32'h80000000
`define DEF_START_VALUE 32'h00000000
`define DEF_FUNC_0 `AUX_GATE_LEVEL
`define DEF_FUNC_1 `AUX_NONE
`define DEF_FUNC_2 `AUX_NONE
`define DEF_REF_MODE `REF_NONE
`define DEF_EDGE `EDGE_RISE
`define DEF_AUX_LOW 3'h0

// Auxiliary input count and field widths of the packed per-input fields
`define AUX_NUM 3
`define FUNC_W 3
`define EDGE_W 2

`endif

// file: encoder_model.sv
// Encoder count stream, index pulse and auxiliary pin model
`timescale 1ns/1ps
`default_nettype none
module encoder_model (
  // Clock
  input wire logic core_clk,
  // Count stream and index
  output logic cnt_pulse,
  output logic cnt_up,
  output logic ref_pulse,
  // Auxiliary pins
  output logic aux_input_0,
  output logic aux_input_1,
  output logic aux_input_2
);
  logic [2:0] pin_ff = 3'h3;
  assign {aux_input_2, aux_input_1, aux_input_0} = pin_ff;
  initial begin
    cnt_pulse = 1'b0;
    cnt_up = 1'b0;
    ref_pulse = 1'b0;
  end
  // Direction flips when idle so a core must not trust it outside a step
  task step(input logic up, input int n);
    @(negedge core_clk);
    cnt_up = up;
    cnt_pulse = 1'b1;
    repeat (n) @(negedge core_clk);
    cnt_pulse = 1'b0;
    cnt_up = ~up;
  endtask
  task index();
    @(negedge core_clk);
    ref_pulse = 1'b1;
    @(negedge core_clk);
    ref_pulse = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  // Five cycles cover the pin synchroniser and the load behind it
  task pin(input int i, input logic v);
    @(negedge core_clk);
    pin_ff[i] = v;
    repeat (5) @(negedge core_clk);
  endtask
endmodule // encoder_model
`default_nettype wire

// file: signed_counter.v
// Signed up/down counting core with limits, gate, sync and capture
`timescale 1ns/1ps
`default_nettype none
`include "counter_defines.vh"

// Overview of operation
// - Reference pulse reaction: none, synchronize or capture; none after reset.
// - Reference synchronization happens once or periodically; once by default.
// - Capture latches once or periodically; once by default.
// - Programmable signed high limit, reset default 2147483647.
// - Programmable signed low limit, reset default -2147483648.
// - On limit crossing, stop or continue counting; continue by default.
// - On crossing reload opposite limit (default) or start value (default 0).
// - Gate opening loads start value or resumes; resume by default.
// - Each auxiliary input gets one of six functions or none.
// - After reset input 0 is level gate, inputs 1 and 2 have none.
// - Each auxiliary input has selectable active polarity, high by default.
// - Edge functions trigger on rising, falling or both edges.
// - After auxiliary capture keep count or load start value.
// - High and low limit crossings flag separately enabled events, off by default.
module signed_counter #(
  parameter WIDTH = 32
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Count stream from the signal evaluation front end (same clock)
  input wire cnt_pulse,
  input wire cnt_up,
  input wire ref_pulse,
  // Auxiliary pins, asynchronous
  input wire aux_input_0,
  input wire aux_input_1,
  input wire aux_input_2,
  // Configuration, taken into the core on cfg_load
  input wire cfg_load,
  input wire [1:0] cfg_ref_mode,
  input wire cfg_sync_periodic,
  input wire cfg_capture_periodic,
  input wire [WIDTH-1:0] cfg_hi_limit,
  input wire [WIDTH-1:0] cfg_lo_limit,
  input wire [WIDTH-1:0] cfg_start_value,
  input wire cfg_stop_on_limit,
  input wire cfg_reload_start,
  input wire cfg_gate_load_start,
  input wire cfg_capture_load_start,
  input wire [8:0] cfg_aux_func,
  input wire [2:0] cfg_aux_low,
  input wire [5:0] cfg_aux_edge,
  input wire cfg_ovf_event_en,
  input wire cfg_unf_event_en,
  // Status
  input wire capture_ack,
  output reg [WIDTH-1:0] count_ff,
  output reg [WIDTH-1:0] capture_ff,
  output reg capture_new_ff,
  output reg gate_open_ff,
  output reg stopped_ff,
  output reg ovf_event_ff,
  output reg unf_event_ff
);

  // Latched configuration
  reg [1:0] ref_mode_ff;
  reg sync_periodic_ff;
  reg capture_periodic_ff;
  reg [WIDTH-1:0] hi_limit_ff;
  reg [WIDTH-1:0] lo_limit_ff;
  reg [WIDTH-1:0] start_value_ff;
  reg stop_on_limit_ff;
  reg reload_start_ff;
  reg gate_load_start_ff;
  reg capture_load_start_ff;
  reg [8:0] aux_func_ff;
  reg [2:0] aux_low_ff;
  reg [5:0] aux_edge_ff;
  reg ovf_en_ff;
  reg unf_en_ff;

  // Input synchronisers and edge history
  reg [2:0] aux_meta_ff;
  reg [2:0] aux_sync_ff;
  reg [2:0] aux_prev_ff;

  // Arming, pending sync and gate state
  reg sync_armed_ff;
  reg capture_armed_ff;
  reg sync_req_ff;
  reg gate_edge_ff;

  reg [2:0] aux_act;
  reg [2:0] aux_prev_act;
  reg [2:0] aux_hit;
  reg level_gate_used;
  reg level_gate_on;
  reg edge_gate_used;
  reg gate_open_req;
  reg gate_close_req;
  reg ref_enable_used;
  reg ref_enable_on;
  reg aux_sync_hit;
  reg aux_capture_hit;
  reg gate_now;
  reg ref_ok;
  reg sync_det;
  reg capture_det;
  reg nxt_gate_edge;
  reg [WIDTH-1:0] nxt_count;
  reg nxt_stopped;
  reg nxt_ovf;
  reg nxt_unf;
  integer i;

  // Selected edge of an active-level signal
  function edge_hit;
    input [1:0] sel;
    input cur;
    input prev;
    begin
      case (sel)
        `EDGE_RISE: edge_hit = cur & ~prev;
        `EDGE_FALL: edge_hit = ~cur & prev;
        `EDGE_BOTH: edge_hit = cur ^ prev;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_mode_ff <= `DEF_REF_MODE;
      sync_periodic_ff <= 1'b0;
      capture_periodic_ff <= 1'b0;
      hi_limit_ff <= `DEF_HI_LIMIT;
      lo_limit_ff <= `DEF_LO_LIMIT;
      start_value_ff <= `DEF_START_VALUE;
      stop_on_limit_ff <= 1'b0;
      reload_start_ff <= 1'b0;
      gate_load_start_ff <= 1'b0;
      capture_load_start_ff <= 1'b0;
      aux_func_ff <= {`DEF_FUNC_2, `DEF_FUNC_1, `DEF_FUNC_0};
      aux_low_ff <= `DEF_AUX_LOW;
      aux_edge_ff <= {`DEF_EDGE, `DEF_EDGE, `DEF_EDGE};
      ovf_en_ff <= 1'b0;
      unf_en_ff <= 1'b0;
    end else if (cfg_load) begin
      ref_mode_ff <= cfg_ref_mode;
      sync_periodic_ff <= cfg_sync_periodic;
      capture_periodic_ff <= cfg_capture_periodic;
      hi_limit_ff <= cfg_hi_limit;
      lo_limit_ff <= cfg_lo_limit;
      start_value_ff <= cfg_start_value;
      stop_on_limit_ff <= cfg_stop_on_limit;
      reload_start_ff <= cfg_reload_start;
      gate_load_start_ff <= cfg_gate_load_start;
      capture_load_start_ff <= cfg_capture_load_start;
      aux_func_ff <= cfg_aux_func;
      aux_low_ff <= cfg_aux_low;
      aux_edge_ff <= cfg_aux_edge;
      ovf_en_ff <= cfg_ovf_event_en;
      unf_en_ff <= cfg_unf_event_en;
    end
  end

  // Pins are asynchronous; only the second and third stages feed logic
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_meta_ff <= 3'h0;
      aux_sync_ff <= 3'h0;
      aux_prev_ff <= 3'h0;
    end else begin
      aux_meta_ff <= {aux_input_2, aux_input_1, aux_input_0};
      aux_sync_ff <= aux_meta_ff;
      aux_prev_ff <= aux_sync_ff;
    end
  end

  // Auxiliary function decode
  always @* begin
    aux_act = aux_sync_ff ^ aux_low_ff;
    aux_prev_act = aux_prev_ff ^ aux_low_ff;
    level_gate_used = 1'b0;
    level_gate_on = 1'b0;
    edge_gate_used = 1'b0;
    gate_open_req = 1'b0;
    gate_close_req = 1'b0;
    ref_enable_used = 1'b0;
    ref_enable_on = 1'b0;
    aux_sync_hit = 1'b0;
    aux_capture_hit = 1'b0;
    for (i = 0; i < `AUX_NUM; i = i + 1) begin
      aux_hit[i] = edge_hit(aux_edge_ff[i*`EDGE_W +: `EDGE_W], aux_act[i],
        aux_prev_act[i]);
      case (aux_func_ff[i*`FUNC_W +: `FUNC_W])
        `AUX_GATE_LEVEL: begin
          level_gate_used = 1'b1;
          level_gate_on = level_gate_on | aux_act[i];
        end
        `AUX_GATE_OPEN: begin
          edge_gate_used = 1'b1;
          gate_open_req = gate_open_req | aux_hit[i];
        end
        `AUX_GATE_CLOSE: begin
          edge_gate_used = 1'b1;
          gate_close_req = gate_close_req | aux_hit[i];
        end
        `AUX_SYNC: aux_sync_hit = aux_sync_hit | aux_hit[i];
        `AUX_REF_ENABLE: begin
          ref_enable_used = 1'b1;
          ref_enable_on = ref_enable_on | aux_act[i];
        end
        `AUX_CAPTURE: aux_capture_hit = aux_capture_hit | aux_hit[i];
        default: ;
      endcase
    end
  end

  // Gate, sync and capture qualification
  always @* begin
    // Close wins over open when both edges land together
    nxt_gate_edge = gate_close_req ? 1'b0 : (gate_open_req ? 1'b1 : gate_edge_ff);
    if (level_gate_used && edge_gate_used)
      gate_now = level_gate_on & nxt_gate_edge;
    else if (level_gate_used)
      gate_now = level_gate_on;
    else if (edge_gate_used)
      gate_now = nxt_gate_edge;
    else
      gate_now = 1'b1;
    ref_ok = ref_pulse & (~ref_enable_used | ref_enable_on);
    sync_det = sync_armed_ff & (aux_sync_hit |
      (ref_ok & (ref_mode_ff == `REF_SYNC)));
    capture_det = capture_armed_ff & (aux_capture_hit |
      (ref_ok & (ref_mode_ff == `REF_CAPTURE)));
  end

  // Next count: sync load, capture load, gate start load, then counting
  always @* begin
    nxt_count = count_ff;
    nxt_stopped = stopped_ff;
    nxt_ovf = 1'b0;
    nxt_unf = 1'b0;
    if (gate_now && !gate_open_ff)
      nxt_stopped = 1'b0;
    if (sync_req_ff) begin
      nxt_count = start_value_ff;
    end else if (capture_det && aux_capture_hit && capture_load_start_ff) begin
      nxt_count = start_value_ff;
    end else if (gate_now && !gate_open_ff && gate_load_start_ff) begin
      nxt_count = start_value_ff;
    end else if (gate_now && !stopped_ff && cnt_pulse) begin
      if (cnt_up && ($signed(count_ff) >= $signed(hi_limit_ff))) begin
        nxt_count = reload_start_ff ? start_value_ff : lo_limit_ff;
        nxt_stopped = stop_on_limit_ff;
        nxt_ovf = ovf_en_ff;
      end else if (!cnt_up && ($signed(count_ff) <= $signed(lo_limit_ff))) begin
        nxt_count = reload_start_ff ? start_value_ff : hi_limit_ff;
        nxt_stopped = stop_on_limit_ff;
        nxt_unf = unf_en_ff;
      end else begin
        nxt_count = cnt_up ? count_ff + 1'b1 : count_ff - 1'b1;
      end
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= `DEF_START_VALUE;
      capture_ff <= `DEF_START_VALUE;
      capture_new_ff <= 1'b0;
      gate_open_ff <= 1'b0;
      gate_edge_ff <= 1'b0;
      stopped_ff <= 1'b0;
      ovf_event_ff <= 1'b0;
      unf_event_ff <= 1'b0;
      sync_req_ff <= 1'b0;
      sync_armed_ff <= 1'b1;
      capture_armed_ff <= 1'b1;
    end else begin
      count_ff <= nxt_count;
      stopped_ff <= nxt_stopped;
      ovf_event_ff <= nxt_ovf;
      unf_event_ff <= nxt_unf;
      gate_open_ff <= gate_now;
      gate_edge_ff <= nxt_gate_edge;
      sync_req_ff <= sync_det;
      // A new configuration re-arms the once-only functions
      if (cfg_load)
        sync_armed_ff <= 1'b1;
      else if (sync_det && !sync_periodic_ff)
        sync_armed_ff <= 1'b0;
      if (cfg_load)
        capture_armed_ff <= 1'b1;
      else if (capture_det && !capture_periodic_ff)
        capture_armed_ff <= 1'b0;
      if (capture_det)
        capture_ff <= count_ff;
      // Set wins over acknowledge so no capture is lost
      if (capture_det)
        capture_new_ff <= 1'b1;
      else if (capture_ack)
        capture_new_ff <= 1'b0;
    end
  end

endmodule // signed_counter
`default_nettype wire

// file: signed_counter_monitor.sv
// Concurrent checks on the ports of the signed counting core
`timescale 1ns/1ps
`default_nettype none
module signed_counter_monitor #(
  parameter WIDTH = 32
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Inputs
  input wire cnt_pulse,
  input wire cnt_up,
  input wire cfg_load,
  input wire [WIDTH-1:0] cfg_hi_limit,
  input wire [WIDTH-1:0] cfg_lo_limit,
  input wire [WIDTH-1:0] cfg_start_value,
  input wire cfg_stop_on_limit,
  input wire cfg_reload_start,
  input wire cfg_ovf_event_en,
  input wire cfg_unf_event_en,
  input wire capture_ack,
  // Outputs
  input wire [WIDTH-1:0] count_ff,
  input wire [WIDTH-1:0] capture_ff,
  input wire capture_new_ff,
  input wire gate_open_ff,
  input wire stopped_ff,
  input wire ovf_event_ff,
  input wire unf_event_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Skip the cfg_load edge, which still counts with the old settings
  wire step_ok = cnt_pulse && gate_open_ff && !stopped_ff && !cfg_load;
  // Crossing is reaching or passing a limit, so compare signed
  wire below_hi = $signed(count_ff) < $signed(cfg_hi_limit);
  wire above_lo = $signed(count_ff) > $signed(cfg_lo_limit);
  // Sync and capture loads may coincide, so the start value is also accepted
  a_count_step: assert property (step_ok && (cnt_up ? below_hi : above_lo)
    ##1 gate_open_ff |-> count_ff == ($past(cnt_up) ? $past(count_ff) + 1'b1
    : $past(count_ff) - 1'b1) || count_ff == $past(cfg_start_value))
    else $error("count step wrong");
  a_hi_reload: assert property (step_ok && cnt_up && !below_hi
    ##1 gate_open_ff |-> count_ff == ($past(cfg_reload_start) ? $past(cfg_start_value)
    : $past(cfg_lo_limit)) && ovf_event_ff == $past(cfg_ovf_event_en)
    && stopped_ff == $past(cfg_stop_on_limit))
    else $error("high limit reload wrong");
  a_lo_reload: assert property (step_ok && !cnt_up && !above_lo
    ##1 gate_open_ff |-> count_ff == ($past(cfg_reload_start) ? $past(cfg_start_value)
    : $past(cfg_hi_limit)) && unf_event_ff == $past(cfg_unf_event_en)
    && stopped_ff == $past(cfg_stop_on_limit))
    else $error("low limit reload wrong");
  a_ovf_cause: assert property (ovf_event_ff |-> $past(cnt_pulse) && $past(cnt_up)
    && $past(cfg_ovf_event_en) && !unf_event_ff)
    else $error("overflow event without cause");
  a_unf_cause: assert property (unf_event_ff |-> $past(cnt_pulse) && !$past(cnt_up)
    && $past(cfg_unf_event_en) && !ovf_event_ff)
    else $error("underflow event without cause");
  a_stop_hold: assert property (stopped_ff && $past(stopped_ff) |-> $stable(count_ff))
    else $error("count moved while stopped");
  a_gate_hold: assert property (!gate_open_ff && !$past(gate_open_ff)
    |-> $stable(count_ff) || count_ff == $past(cfg_start_value))
    else $error("count moved with gate closed");
  a_capture_copy: assert property ($rose(capture_new_ff)
    |-> capture_ff == $past(count_ff) || capture_ff == $past(count_ff, 2))
    else $error("captured value wrong");
  a_capture_sticky: assert property ($past(capture_new_ff) && !$past(capture_ack)
    |-> capture_new_ff)
    else $error("capture flag dropped");
  c_ovf: cover property (ovf_event_ff);
  c_unf: cover property (unf_event_ff);
  c_capture: cover property ($rose(capture_new_ff));
endmodule // signed_counter_monitor
`default_nettype wire

// file: test_signed_counter.sv
// Self-checking bench for the signed counting core
`timescale 1ns/1ps
`default_nettype none
`include "counter_defines.vh"
module test_signed_counter;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_load = 1'b0;
  logic [1:0] cfg_ref_mode = `DEF_REF_MODE;
  logic cfg_sync_periodic = 1'b0, cfg_capture_periodic = 1'b0;
  logic [31:0] cfg_hi_limit = `DEF_HI_LIMIT, cfg_lo_limit = `DEF_LO_LIMIT;
  logic [31:0] cfg_start_value = `DEF_START_VALUE;
  logic cfg_stop_on_limit = 1'b0, cfg_reload_start = 1'b0, cfg_gate_load_start = 1'b0;
  logic cfg_capture_load_start = 1'b0, cfg_ovf_event_en = 1'b0, cfg_unf_event_en = 1'b0;
  logic [8:0] cfg_aux_func = {`DEF_FUNC_2, `DEF_FUNC_1, `DEF_FUNC_0};
  logic [2:0] cfg_aux_low = 3'h0;
  logic [5:0] cfg_aux_edge = 6'h0;
  logic capture_ack = 1'b0;
  wire cnt_pulse, cnt_up, ref_pulse, aux_input_0, aux_input_1, aux_input_2;
  wire [31:0] count_ff, capture_ff;
  wire capture_new_ff, gate_open_ff, stopped_ff, ovf_event_ff, unf_event_ff;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  encoder_model enc (.core_clk, .cnt_pulse, .cnt_up, .ref_pulse, .aux_input_0, .aux_input_1,
    .aux_input_2);
  signed_counter #(.WIDTH(32)) dut (.core_clk, .rst_n, .cnt_pulse, .cnt_up, .ref_pulse,
    .aux_input_0, .aux_input_1, .aux_input_2, .cfg_load, .cfg_ref_mode, .cfg_sync_periodic,
    .cfg_capture_periodic, .cfg_hi_limit, .cfg_lo_limit, .cfg_start_value, .cfg_stop_on_limit,
    .cfg_reload_start, .cfg_gate_load_start, .cfg_capture_load_start, .cfg_aux_func,
    .cfg_aux_low, .cfg_aux_edge, .cfg_ovf_event_en, .cfg_unf_event_en, .capture_ack,
    .count_ff, .capture_ff, .capture_new_ff, .gate_open_ff, .stopped_ff, .ovf_event_ff,
    .unf_event_ff);
  initial forever #5 core_clk = ~core_clk;
  task results();
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // A hung wait would otherwise never reach the verdict
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      results();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task load();
    @(negedge core_clk) cfg_load = 1'b1;
    @(negedge core_clk) cfg_load = 1'b0;
  endtask
  initial begin
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    enc.pin(0, 1'b1);
    enc.step(1'b1, 3);
    chk(count_ff, 32'h3);
    enc.index();
    chk(count_ff, 32'h3);
    enc.pin(1, 1'b0);
    enc.pin(0, 1'b0);
    chk(gate_open_ff, 32'h0);
    enc.step(1'b1, 2);
    chk(count_ff, 32'h3);
    enc.pin(0, 1'b1);
    enc.pin(1, 1'b1);
    cfg_hi_limit = 32'h5;
    cfg_lo_limit = 32'hfffffffe;
    cfg_ovf_event_en = 1'b1;
    cfg_unf_event_en = 1'b1;
    load();
    enc.step(1'b1, 3);
    chk(count_ff, 32'hfffffffe);
    chk(ovf_event_ff, 32'h1);
    enc.step(1'b0, 1);
    chk(count_ff, 32'h5);
    chk(unf_event_ff, 32'h1);
    cfg_reload_start = 1'b1;
    cfg_start_value = 32'h1;
    load();
    enc.step(1'b1, 1);
    chk(count_ff, 32'h1);
    cfg_reload_start = 1'b0;
    cfg_stop_on_limit = 1'b1;
    cfg_gate_load_start = 1'b1;
    load();
    enc.step(1'b1, 6);
    chk(count_ff, 32'hfffffffe);
    chk(stopped_ff, 32'h1);
    enc.pin(0, 1'b0);
    enc.pin(0, 1'b1);
    chk(count_ff, 32'h1);
    chk(stopped_ff, 32'h0);
    cfg_stop_on_limit = 1'b0;
    cfg_gate_load_start = 1'b0;
    cfg_aux_func = {`AUX_NONE, `AUX_GATE_CLOSE, `AUX_GATE_OPEN};
    cfg_aux_low = 3'h2;
    cfg_aux_edge = {2'h0, `EDGE_FALL, `EDGE_RISE};
    load();
    enc.pin(0, 1'b0);
    enc.pin(0, 1'b1);
    enc.pin(1, 1'b0);
    enc.step(1'b1, 1);
    chk(count_ff, 32'h2);
    enc.pin(1, 1'b1);
    enc.step(1'b1, 1);
    chk(count_ff, 32'h2);
    cfg_aux_func = {`AUX_SYNC, `AUX_NONE, `AUX_GATE_LEVEL};
    cfg_aux_edge[5:4] = `EDGE_BOTH;
    cfg_sync_periodic = 1'b1;
    cfg_start_value = 32'h0;
    load();
    enc.pin(2, 1'b1);
    chk(count_ff, 32'h0);
    enc.step(1'b1, 3);
    enc.pin(2, 1'b0);
    chk(count_ff, 32'h0);
    cfg_ref_mode = `REF_SYNC;
    cfg_sync_periodic = 1'b0;
    cfg_aux_func[8:6] = `AUX_REF_ENABLE;
    load();
    enc.pin(2, 1'b1);
    enc.step(1'b1, 2);
    enc.index();
    chk(count_ff, 32'h0);
    enc.step(1'b1, 2);
    enc.index();
    chk(count_ff, 32'h2);
    cfg_ref_mode = `REF_CAPTURE;
    cfg_aux_func[8:6] = `AUX_NONE;
    load();
    enc.index();
    chk(capture_ff, 32'h2);
    chk(capture_new_ff, 32'h1);
    @(negedge core_clk) capture_ack = 1'b1;
    @(negedge core_clk) capture_ack = 1'b0;
    chk(capture_new_ff, 32'h0);
    enc.step(1'b1, 1);
    enc.index();
    chk(capture_ff, 32'h2);
    cfg_ref_mode = `REF_NONE;
    cfg_aux_func[5:3] = `AUX_CAPTURE;
    cfg_aux_edge[3:2] = `EDGE_RISE;
    cfg_capture_periodic = 1'b1;
    cfg_capture_load_start = 1'b1;
    load();
    enc.pin(1, 1'b0);
    chk(capture_ff, 32'h3);
    chk(count_ff, 32'h0);
    results();
  end
endmodule // test_signed_counter
bind signed_counter signed_counter_monitor #(.WIDTH(WIDTH)) mon (.core_clk, .rst_n, .cnt_pulse,
  .cnt_up, .cfg_load, .cfg_hi_limit, .cfg_lo_limit, .cfg_start_value, .cfg_stop_on_limit,
  .cfg_reload_start, .cfg_ovf_event_en, .cfg_unf_event_en, .capture_ack, .count_ff, .capture_ff,
  .capture_new_ff,
  .gate_open_ff, .stopped_ff, .ovf_event_ff, .unf_event_ff);
`default_nettype wire
